//--- design/scss_regs.vh
`ifndef SCSS_REGS_VH
`define SCSS_REGS_VH
`define SCSS_CLK_NS 10
`define SCSS_PHASE_NS 2000
// Phase length in clocks, 2000 ns at 10 ns
`define SCSS_PHASE_CYC 20'h0_00C8
`define SCSS_GAP_CYC 20'h0_0001
`define SCSS_DISCHARGE_US 1000
// Discharge length in clocks, 1 ms at 10 ns
`define SCSS_DISCHARGE_CYC 20'h1_86A0
`define SCSS_CNT_W 24
`define SCSS_TMR_W 20
`define SCSS_SW_LIMIT 24'hFF_FFFF
`endif

//--- design/scss_timer.v
`timescale 1ns/10ps
// Down-counter flagging when a loaded interval has expired
module scss_timer (
   // Clock and reset
   input wire ref_clk,
   input wire rst,
   // Control
   input wire load,
   input wire [19:0] load_value,
   // Status
   output reg expired
);
   reg [19:0] count;
   always @(posedge ref_clk) begin
      if (rst) begin
         count <= 20'h0_0000;
         expired <= 1'b0;
      end else if (load) begin
         count <= load_value;
         expired <= 1'b0;
      end else if (count > 20'h0_0001) begin
         count <= count - 20'h0_0001;
      end else begin
         count <= 20'h0_0000;
         expired <= 1'b1;
      end
   end
endmodule

//--- design/scss_sequencer.v
`timescale 1ns/10ps
`include "scss_regs.vh"
module scss_sequencer #(
   parameter [19:0] DISCHARGE_CYC = `SCSS_DISCHARGE_CYC
) (
   // Clock and reset
   input wire ref_clk,
   input wire rst,
   // Control
   input wire start,
   // Comparator: high while integrator voltage above active reference
   input wire comparator_out,
   // Reference select: high picks upper_reference
   output reg ref_select_upper,
   // Sense-drive pin
   output reg sense_drive_pin_out,
   output reg sense_drive_pin_oe,
   // Comparator sense pin
   output reg comparator_sense_pin_oe,
   // Calibration resistor pin
   output reg cal_resistor_pin_out,
   output reg cal_resistor_pin_oe,
   // Integrator-low pin
   output reg integrator_low_pin_out,
   output reg integrator_low_pin_oe,
   // Switch clock and results
   output reg switch_clock,
   output reg busy,
   output reg done,
   output reg overflow,
   output reg [23:0] switching_count,
   output reg [23:0] calibration_count
);
   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_DISCHARGE = 3'h1;
   localparam [2:0] ST_CHARGE = 3'h2;
   localparam [2:0] ST_GAP_A = 3'h3;
   localparam [2:0] ST_SHARE = 3'h4;
   localparam [2:0] ST_GAP_B = 3'h5;
   localparam [2:0] ST_CAL = 3'h6;
   localparam [19:0] PHASE_CYC = `SCSS_PHASE_CYC;
   localparam [19:0] GAP_CYC = `SCSS_GAP_CYC;

   reg [2:0] state;
   reg [2:0] next_state;
   reg [23:0] sw_cnt;
   reg [23:0] cal_cnt;
   reg tmr_load;
   reg [19:0] tmr_value;
   wire tmr_expired;

   // Pin pattern: {sense_oe, sense_out, cal_oe, low_oe}; driven outs are zero otherwise
   function [3:0] pin_pattern;
      input [2:0] st;
      begin
         case (st)
            ST_DISCHARGE: pin_pattern = 4'hB;
            ST_CHARGE: pin_pattern = 4'hC;
            ST_SHARE: pin_pattern = 4'h1;
            ST_CAL: pin_pattern = 4'h3;
            default: pin_pattern = 4'h0;
         endcase
      end
   endfunction

   scss_timer u_timer (
      .ref_clk(ref_clk),
      .rst(rst),
      .load(tmr_load),
      .load_value(tmr_value),
      .expired(tmr_expired)
   );

   // Sequencing
   always @* begin
      next_state = state;
      tmr_load = 1'b0;
      tmr_value = PHASE_CYC;
      case (state)
         ST_IDLE: begin
            if (start) begin
               next_state = ST_DISCHARGE;
               tmr_load = 1'b1;
               tmr_value = DISCHARGE_CYC;
            end
         end
         ST_DISCHARGE: begin
            if (tmr_expired) begin
               next_state = ST_GAP_B;
               tmr_load = 1'b1;
               tmr_value = GAP_CYC;
            end
         end
         ST_CHARGE: begin
            if (tmr_expired) begin
               next_state = ST_GAP_A;
               tmr_load = 1'b1;
               tmr_value = GAP_CYC;
            end
         end
         ST_GAP_A: begin
            if (tmr_expired) begin
               next_state = ST_SHARE;
               tmr_load = 1'b1;
            end
         end
         ST_SHARE: begin
            if (tmr_expired) begin
               next_state = ST_GAP_B;
               tmr_load = 1'b1;
               tmr_value = GAP_CYC;
            end
         end
         ST_GAP_B: begin
            if (busy && sw_cnt != 24'h00_0000 && comparator_out) begin
               next_state = ST_CAL;
            end else if (sw_cnt == `SCSS_SW_LIMIT) begin
               next_state = ST_IDLE;
            end else if (tmr_expired) begin
               next_state = ST_CHARGE;
               tmr_load = 1'b1;
            end
         end
         ST_CAL: begin
            if (!comparator_out || cal_cnt == `SCSS_SW_LIMIT) begin
               next_state = ST_IDLE;
            end
         end
         default: next_state = ST_IDLE;
      endcase
   end

   // Run events
   wire run_start;
   wire share_end;
   wire cal_enter;
   wire run_end;
   wire cal_finished;
   wire [3:0] next_pins;
   wire next_sense_oe;
   wire next_sense_out;
   wire next_cal_oe;
   wire next_low_oe;

   assign run_start = (state == ST_IDLE) && start;
   assign share_end = (state == ST_SHARE) && tmr_expired;
   assign cal_enter = (state == ST_GAP_B) && (next_state == ST_CAL);
   assign run_end = (state != ST_IDLE) && (next_state == ST_IDLE);
   assign cal_finished = (state == ST_CAL) && !comparator_out;
   assign next_pins = pin_pattern(next_state);
   assign next_sense_oe = next_pins[3];
   assign next_sense_out = next_pins[2];
   assign next_cal_oe = next_pins[1];
   assign next_low_oe = next_pins[0];

   // State register
   always @(posedge ref_clk) begin
      if (rst) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Whole switching periods
   always @(posedge ref_clk) begin
      if (rst) begin
         sw_cnt <= 24'h00_0000;
      end else if (run_start) begin
         sw_cnt <= 24'h00_0000;
      end else if (share_end) begin
         sw_cnt <= sw_cnt + 24'h00_0001;
      end
   end

   // Clocks spent in calibration
   always @(posedge ref_clk) begin
      if (rst) begin
         cal_cnt <= 24'h00_0000;
      end else if (run_start) begin
         cal_cnt <= 24'h00_0000;
      end else if (state == ST_CAL) begin
         cal_cnt <= cal_cnt + 24'h00_0001;
      end
   end

   // Measurement running
   always @(posedge ref_clk) begin
      if (rst) begin
         busy <= 1'b0;
      end else if (run_start) begin
         busy <= 1'b1;
      end else if (run_end) begin
         busy <= 1'b0;
      end
   end

   // End of run pulse
   always @(posedge ref_clk) begin
      if (rst) begin
         done <= 1'b0;
      end else begin
         done <= run_end;
      end
   end

   // Run ended at the count limit
   always @(posedge ref_clk) begin
      if (rst) begin
         overflow <= 1'b0;
      end else if (run_start) begin
         overflow <= 1'b0;
      end else if (run_end && !cal_finished) begin
         overflow <= 1'b1;
      end
   end

   // Switching result
   always @(posedge ref_clk) begin
      if (rst) begin
         switching_count <= 24'h00_0000;
      end else if (cal_enter) begin
         switching_count <= sw_cnt;
      end
   end

   // Calibration result, last clock included
   always @(posedge ref_clk) begin
      if (rst) begin
         calibration_count <= 24'h00_0000;
      end else if (run_end && cal_finished) begin
         calibration_count <= cal_cnt + 24'h00_0001;
      end
   end

   // Upper reference except during calibration
   always @(posedge ref_clk) begin
      if (rst) begin
         ref_select_upper <= 1'b1;
      end else if (run_start) begin
         ref_select_upper <= 1'b1;
      end else if (cal_enter) begin
         ref_select_upper <= 1'b0;
      end else if (run_end) begin
         ref_select_upper <= 1'b1;
      end
   end

   // Switch clock high over charge and its gap
   always @(posedge ref_clk) begin
      if (rst) begin
         switch_clock <= 1'b0;
      end else begin
         switch_clock <= (next_state == ST_CHARGE) || (next_state == ST_GAP_A);
      end
   end

   // Sense-drive pin enable
   always @(posedge ref_clk) begin
      if (rst) begin
         sense_drive_pin_oe <= 1'b0;
      end else begin
         sense_drive_pin_oe <= next_sense_oe;
      end
   end

   // Sense-drive pin level
   always @(posedge ref_clk) begin
      if (rst) begin
         sense_drive_pin_out <= 1'b0;
      end else begin
         sense_drive_pin_out <= next_sense_out;
      end
   end

   // Comparator sense pin never driven
   always @(posedge ref_clk) begin
      if (rst) begin
         comparator_sense_pin_oe <= 1'b0;
      end else begin
         comparator_sense_pin_oe <= 1'b0;
      end
   end

   // Calibration resistor pin enable
   always @(posedge ref_clk) begin
      if (rst) begin
         cal_resistor_pin_oe <= 1'b0;
      end else begin
         cal_resistor_pin_oe <= next_cal_oe;
      end
   end

   // Calibration resistor pin only ever pulls low
   always @(posedge ref_clk) begin
      if (rst) begin
         cal_resistor_pin_out <= 1'b0;
      end else begin
         cal_resistor_pin_out <= 1'b0;
      end
   end

   // Integrator-low pin enable
   always @(posedge ref_clk) begin
      if (rst) begin
         integrator_low_pin_oe <= 1'b0;
      end else begin
         integrator_low_pin_oe <= next_low_oe;
      end
   end

   // Integrator-low pin only ever pulls low
   always @(posedge ref_clk) begin
      if (rst) begin
         integrator_low_pin_out <= 1'b0;
      end else begin
         integrator_low_pin_out <= 1'b0;
      end
   end
endmodule

//--- bench/scss_cap_model.sv
`timescale 1ns/10ps
// Sensor network and comparator seen from the pins
module scss_cap_model (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Pins of the sequencer
   input wire logic sense_drive_pin_oe,
   input wire logic cal_resistor_pin_oe,
   input wire logic integrator_low_pin_oe,
   // Scenario targets
   input wire logic [7:0] n_target,
   input wire logic [7:0] cal_target,
   // Comparator
   output logic comparator_out
);
   logic [7:0] shares;
   logic [7:0] cal_cyc;
   logic low_oe_q;
   always @(posedge ref_clk) begin
      low_oe_q <= integrator_low_pin_oe;
      if (rst || (sense_drive_pin_oe && cal_resistor_pin_oe)) begin
         shares <= 8'h00;
         cal_cyc <= 8'h00;
      end else if (cal_resistor_pin_oe) begin
         cal_cyc <= cal_cyc + 8'h01;
      end else if (integrator_low_pin_oe && !low_oe_q) begin
         shares <= shares + 8'h01;
      end
   end
   // Rises after the target share count, decays in calibration
   always @* begin
      if (cal_resistor_pin_oe && !sense_drive_pin_oe) comparator_out = cal_cyc < cal_target;
      else comparator_out = (shares >= n_target) && (shares != 8'h00);
   end
endmodule

//--- bench/scss_checker.sv
`timescale 1ns/10ps
module scss_checker (
   // Clock and reset
   input wire ref_clk,
   input wire rst,
   // Pins
   input wire sense_drive_pin_out,
   input wire sense_drive_pin_oe,
   input wire comparator_sense_pin_oe,
   input wire cal_resistor_pin_out,
   input wire cal_resistor_pin_oe,
   input wire integrator_low_pin_out,
   input wire integrator_low_pin_oe,
   // Status
   input wire switch_clock,
   input wire busy,
   input wire done
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   a_cmp_always_input: assert property (!comparator_sense_pin_oe)
      else $error("comparator pin driven");
   a_cal_float_sw: assert property (switch_clock |-> !cal_resistor_pin_oe)
      else $error("cal pin driven in switching");
   a_charge_pin_state: assert property (switch_clock && sense_drive_pin_oe |->
      sense_drive_pin_out && !integrator_low_pin_oe) else $error("charge pins");
   a_no_drive_clash: assert property (!(sense_drive_pin_oe && sense_drive_pin_out
      && integrator_low_pin_oe)) else $error("sense and low pins clash");
   a_share_gap_first: assert property ($rose(integrator_low_pin_oe) && !cal_resistor_pin_oe
      |-> !$past(sense_drive_pin_oe)) else $error("no gap");
   a_driven_zero: assert property (cal_resistor_pin_oe |-> !cal_resistor_pin_out
      && !integrator_low_pin_out) else $error("nonzero drive");
   a_charge_len: assert property ($rose(switch_clock) |-> switch_clock [*8])
      else $error("short charge");
   a_discharge_first: assert property ($rose(busy) |-> ##[0:2] (sense_drive_pin_oe
      && cal_resistor_pin_oe && integrator_low_pin_oe)) else $error("no discharge");
   a_done_single: assert property (done |-> !busy ##1 !done) else $error("done long");
   c_charge: cover property ($rose(switch_clock));
   c_cal: cover property ($rose(cal_resistor_pin_oe) && !sense_drive_pin_oe);
   c_done: cover property (done);
endmodule
bind scss_sequencer scss_checker u_chk (.ref_clk(ref_clk), .rst(rst),
   .sense_drive_pin_out(sense_drive_pin_out), .sense_drive_pin_oe(sense_drive_pin_oe),
   .comparator_sense_pin_oe(comparator_sense_pin_oe), .cal_resistor_pin_out(cal_resistor_pin_out),
   .cal_resistor_pin_oe(cal_resistor_pin_oe), .integrator_low_pin_out(integrator_low_pin_out),
   .integrator_low_pin_oe(integrator_low_pin_oe), .switch_clock(switch_clock), .busy(busy),
   .done(done));

//--- bench/tb_top.sv
`timescale 1ns/10ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin bad_count++; \
   $display("unexpected at %0t: value mismatch", $time); end end
module tb_top;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic start = 1'b0;
   logic [7:0] n_target = 8'h01;
   logic [7:0] cal_target = 8'h01;
   wire comparator_out, ref_select_upper, sense_drive_pin_out, sense_drive_pin_oe;
   wire comparator_sense_pin_oe, cal_resistor_pin_out, cal_resistor_pin_oe;
   wire integrator_low_pin_out, integrator_low_pin_oe, switch_clock, busy, done, overflow;
   wire [23:0] switching_count, calibration_count;
   int bad_count = 0;
   int num_checks = 0;
   always #5 ref_clk = ~ref_clk;
   scss_sequencer #(.DISCHARGE_CYC(20'h0_0014)) u_dut (.ref_clk(ref_clk), .rst(rst),
      .start(start), .comparator_out(comparator_out), .ref_select_upper(ref_select_upper),
      .sense_drive_pin_out(sense_drive_pin_out), .sense_drive_pin_oe(sense_drive_pin_oe),
      .comparator_sense_pin_oe(comparator_sense_pin_oe), .cal_resistor_pin_out(cal_resistor_pin_out),
      .cal_resistor_pin_oe(cal_resistor_pin_oe), .integrator_low_pin_out(integrator_low_pin_out),
      .integrator_low_pin_oe(integrator_low_pin_oe), .switch_clock(switch_clock), .busy(busy),
      .done(done), .overflow(overflow), .switching_count(switching_count),
      .calibration_count(calibration_count));
   scss_cap_model u_net (.ref_clk(ref_clk), .rst(rst), .sense_drive_pin_oe(sense_drive_pin_oe),
      .cal_resistor_pin_oe(cal_resistor_pin_oe), .integrator_low_pin_oe(integrator_low_pin_oe),
      .n_target(n_target), .cal_target(cal_target), .comparator_out(comparator_out));
   task automatic conclude();
      $display("checks %0d, mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic t_reset();
      `CHK({sense_drive_pin_oe, cal_resistor_pin_oe, integrator_low_pin_oe}, 3'b000)
      `CHK({busy, done, switch_clock, ref_select_upper}, 4'b0001)
      `CHK(switching_count, 24'h00_0000)
   endtask
   // One measurement, with a second start mid-run that must be ignored
   task automatic t_measure(input logic [7:0] n, input logic [7:0] c);
      int dones;
      int cyc;
      int refbad;
      dones = 0;
      refbad = 0;
      @(posedge ref_clk);
      n_target <= n;
      cal_target <= c;
      start <= 1'b1;
      @(posedge ref_clk);
      start <= 1'b0;
      repeat (60) @(posedge ref_clk);
      start <= 1'b1;
      @(posedge ref_clk);
      start <= 1'b0;
      for (cyc = 0; cyc < 6000 && !(dones > 0 && busy === 1'b0); cyc++) begin
         @(posedge ref_clk);
         #1;
         if (done === 1'b1) dones++;
         if ((cal_resistor_pin_oe === 1'b1 && sense_drive_pin_oe === 1'b0)
            !== (ref_select_upper === 1'b0)) refbad++;
      end
      `CHK(dones, 1)
      `CHK(refbad, 0)
      `CHK(switching_count, {16'h0000, n})
      `CHK(calibration_count, {16'h0000, c} + 24'h00_0001)
      `CHK(overflow, 1'b0)
   endtask
   initial begin
      repeat (8) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      #1;
      t_reset();
      t_measure(8'h03, 8'h0A);
      t_measure(8'h01, 8'h05);
      conclude();
   end
   initial begin
      repeat (20000) @(posedge ref_clk);
      bad_count++;
      conclude();
   end
endmodule
